// ===== int_agg_pkg.sv
// Constants for the device interrupt aggregator: register indices, field positions, resets.
// Assumes a single 100 MHz core clock and a plain strobe-based register port.
package int_agg_pkg;
  localparam int unsigned ADDR_W = 4;
  localparam int unsigned DATA_W = 32;
  localparam logic [ADDR_W-1:0] ADDR_SCRATCH = 4'h0;
  localparam logic [ADDR_W-1:0] ADDR_ENABLE  = 4'h4;
  localparam logic [ADDR_W-1:0] ADDR_STATUS  = 4'h8;
  localparam logic [DATA_W-1:0] RESET_WORD   = 32'h0000_0000;
  // Writable bits of the enable register; reserved bits 30, 26, 18, 13:9 and loss-limit bit 22 stay zero
  localparam logic [DATA_W-1:0] ENABLE_MASK  = 32'hbbbb_c1ff;
  localparam int unsigned BIT_GLOBAL     = 31;
  localparam int unsigned BIT_LOAD_FAIL  = 29;
  localparam int unsigned BIT_LOAD_ERR   = 28;
  localparam int unsigned BIT_MANUAL     = 27;
  localparam int unsigned LSB_LOS_LMT    = 21;
  localparam int unsigned MSB_LOS_LMT    = 25;
  localparam int unsigned BIT_DLOOP_LMT  = 20;
  localparam int unsigned BIT_ALOOP_LMT  = 19;
  localparam int unsigned LSB_FREQ       = 14;
  localparam int unsigned MSB_FREQ       = 17;
  localparam int unsigned LSB_LOS        = 4;
  localparam int unsigned MSB_LOS        = 8;
  localparam int unsigned BIT_DLOOP_STCH = 3;
  localparam int unsigned BIT_DLOOP_HOLD = 2;
  localparam int unsigned BIT_DLOOP_UNLK = 1;
  localparam int unsigned BIT_ALOOP_UNLK = 0;
  localparam int unsigned SCR_DIV_DIS    = 3;
  localparam int unsigned SCR_FB_DIS     = 2;
  localparam int unsigned SCR_DIV_RST    = 1;
  localparam int unsigned SCR_RC_SEL     = 0;
endpackage

// ===== device_interrupt_aggregator.sv
// Device interrupt aggregator: event mirror, per-source enables, global interrupt, scratch word.
// Assumes event inputs synchronous to clk and a bus master that never overlaps strobes.
//
// Notes on behaviour
// - Status bit 31 is OR of other status bits masked by enables.
// - Interrupt asserts only when bit 31 pending and global enable set.
// - Masked global interrupt drives the GPIO-routed interrupt output.
// - Status 29 is fuse load failure OR external ROM load failure.
// - Status 28 is fuse checksum error OR external ROM checksum error.
// - Status 27 mirrors fuse manual request done.
// - Status 25..21 mirror loss-limit events of reference and clock inputs 3..0.
// - Status 20 mirrors digital loop unlock-limit, 19 analog loop unlock-limit.
// - Status 17..14 mirror frequency monitor events of clock inputs 3..0.
// - Status 8..4 mirror loss events of reference and clock inputs 3..0.
// - Status 3 digital loop state change, 2 digital loop holdover.
// - Status 1 digital loop unlock, 0 analog loop unlock.
// - Per-source enables reset to zero and gate their source into status bit 31; the bit 22 enable is not writable.
// - A 32-bit read-write scratch word resets to zero.
// - Scratch bit 3 forces system clock divider enable low.
// - Scratch bit 2 forces analog loop feedback divider enable low.
// - Scratch bit 1 holds system clock divider in reset.
// - Scratch bit 0 selects RC oscillator; software sets it only when ready.
`timescale 1ns/1ns
module device_interrupt_aggregator
  import int_agg_pkg::*;
(
  input  wire logic                           clk,
  input  wire logic                           reset,
  input  wire logic [int_agg_pkg::ADDR_W-1:0] addr,
  input  wire logic [int_agg_pkg::DATA_W-1:0] wdata,
  input  wire logic                           wr,
  input  wire logic                           rd,
  output logic      [int_agg_pkg::DATA_W-1:0] rdata,
  input  wire logic                           fuse_load_fail,
  input  wire logic                           rom_load_fail,
  input  wire logic                           fuse_crc_err,
  input  wire logic                           rom_crc_err,
  input  wire logic                           fuse_manual_done,
  input  wire logic [4:0]                     los_limit_evt,
  input  wire logic                           digital_loop_unlock_limit,
  input  wire logic                           analog_loop_unlock_limit,
  input  wire logic [3:0]                     freq_evt,
  input  wire logic [4:0]                     los_evt,
  input  wire logic                           digital_loop_state_change,
  input  wire logic                           digital_loop_holdover,
  input  wire logic                           digital_loop_unlock,
  input  wire logic                           analog_loop_unlock,
  output logic                                device_irq,
  output logic                                sysclk_div_enable_force_low,
  output logic                                fb_div_enable_force_low,
  output logic                                sysclk_div_reset,
  output logic                                core_clk_rc_select
);
  import int_agg_pkg::*;

  logic [DATA_W-1:0] software_scratch_word;
  logic [DATA_W-1:0] interrupt_enable_mask;
  logic [DATA_W-1:0] sources;
  logic [DATA_W-1:0] interrupt_pending_flags;
  logic [DATA_W-1:0] next_rdata;
  logic              global_pending;
  logic              next_irq;
  wire               wr_scratch = wr && (addr == ADDR_SCRATCH);
  wire               wr_enable  = wr && (addr == ADDR_ENABLE);

  // Pure mirror of event inputs; no storage so clearing at the source clears here
  always_comb
  begin
    sources                              = RESET_WORD;
    sources[BIT_LOAD_FAIL]               = fuse_load_fail | rom_load_fail;
    sources[BIT_LOAD_ERR]                = fuse_crc_err | rom_crc_err;
    sources[BIT_MANUAL]                  = fuse_manual_done;
    sources[MSB_LOS_LMT:LSB_LOS_LMT]     = los_limit_evt;
    sources[BIT_DLOOP_LMT]               = digital_loop_unlock_limit;
    sources[BIT_ALOOP_LMT]               = analog_loop_unlock_limit;
    sources[MSB_FREQ:LSB_FREQ]           = freq_evt;
    sources[MSB_LOS:LSB_LOS]             = los_evt;
    sources[BIT_DLOOP_STCH]              = digital_loop_state_change;
    sources[BIT_DLOOP_HOLD]              = digital_loop_holdover;
    sources[BIT_DLOOP_UNLK]              = digital_loop_unlock;
    sources[BIT_ALOOP_UNLK]              = analog_loop_unlock;
  end

  // Global enable bit is excluded from the per-source OR by a constant mask on bit 31
  assign global_pending = |(sources & interrupt_enable_mask & ~(32'h1 << BIT_GLOBAL));

  always_comb
  begin
    interrupt_pending_flags             = sources;
    interrupt_pending_flags[BIT_GLOBAL] = global_pending;
  end

  assign next_irq = global_pending & interrupt_enable_mask[BIT_GLOBAL];

  assign next_rdata = (addr == ADDR_SCRATCH) ? software_scratch_word :
                      (addr == ADDR_ENABLE)  ? interrupt_enable_mask :
                      (addr == ADDR_STATUS)  ? interrupt_pending_flags : RESET_WORD;

  always_ff @(posedge clk)
  begin
    if (reset)
    begin
      software_scratch_word <= RESET_WORD;
      interrupt_enable_mask <= RESET_WORD;
    end
    else
    begin
      if (wr_scratch)
        software_scratch_word <= wdata;
      if (wr_enable)
        interrupt_enable_mask <= wdata & ENABLE_MASK;
    end
  end

  // Read data valid only in the cycle after the strobe; zero otherwise
  always_ff @(posedge clk)
  begin
    if (reset)
      rdata <= RESET_WORD;
    else if (rd)
      rdata <= next_rdata;
    else
      rdata <= RESET_WORD;
  end

  // Registered outputs: one cycle latency from event or register change
  always_ff @(posedge clk)
  begin
    if (reset)
    begin
      device_irq                  <= 1'b0;
      sysclk_div_enable_force_low <= 1'b0;
      fb_div_enable_force_low     <= 1'b0;
      sysclk_div_reset            <= 1'b0;
      core_clk_rc_select          <= 1'b0;
    end
    else
    begin
      device_irq                  <= next_irq;
      sysclk_div_enable_force_low <= software_scratch_word[SCR_DIV_DIS];
      fb_div_enable_force_low     <= software_scratch_word[SCR_FB_DIS];
      sysclk_div_reset            <= software_scratch_word[SCR_DIV_RST];
      // Glitch-free mux lives in the clock generator; ordering is software's duty
      core_clk_rc_select          <= software_scratch_word[SCR_RC_SEL];
    end
  end

  AST_IRQ_CAUSE: assert property (@(posedge clk) disable iff (reset)
    device_irq |-> $past(global_pending && interrupt_enable_mask[BIT_GLOBAL]))
    else $error("irq without enabled pending source");
  AST_IRQ_SET: assert property (@(posedge clk) disable iff (reset)
    (global_pending && interrupt_enable_mask[BIT_GLOBAL]) |=> device_irq)
    else $error("irq missed");
  AST_GLOBAL_OR: assert property (@(posedge clk) disable iff (reset)
    global_pending == |(sources[BIT_LOAD_FAIL:0] & interrupt_enable_mask[BIT_LOAD_FAIL:0]))
    else $error("global pending mismatch");
  AST_MASK_BLOCK: assert property (@(posedge clk) disable iff (reset)
    (interrupt_enable_mask == RESET_WORD) |-> !global_pending)
    else $error("pending with no enables");
  AST_LOAD_FAIL: assert property (@(posedge clk) disable iff (reset)
    interrupt_pending_flags[BIT_LOAD_FAIL] == (fuse_load_fail || rom_load_fail))
    else $error("load fail status wrong");
  AST_LOAD_ERR: assert property (@(posedge clk) disable iff (reset)
    interrupt_pending_flags[BIT_LOAD_ERR] == (fuse_crc_err || rom_crc_err))
    else $error("load err status wrong");
  AST_MIRROR: assert property (@(posedge clk) disable iff (reset)
    rd && addr == ADDR_STATUS |=> rdata[MSB_LOS:LSB_LOS] == $past(los_evt))
    else $error("status read wrong");
  AST_SCRATCH_RW: assert property (@(posedge clk) disable iff (reset)
    wr_scratch ##1 (rd && addr == ADDR_SCRATCH) |=> rdata == $past(wdata, 2))
    else $error("scratch readback wrong");
  AST_RC_SEL: assert property (@(posedge clk) disable iff (reset)
    wr_scratch ##1 !wr_scratch |=> core_clk_rc_select == $past(wdata[SCR_RC_SEL], 2))
    else $error("rc select not following scratch");
  AST_DIV_CTRL: assert property (@(posedge clk) disable iff (reset)
    wr_scratch ##1 !wr_scratch |=> (sysclk_div_reset == $past(wdata[SCR_DIV_RST], 2)
      && sysclk_div_enable_force_low == $past(wdata[SCR_DIV_DIS], 2)
      && fb_div_enable_force_low == $past(wdata[SCR_FB_DIS], 2)))
    else $error("divider controls wrong");

  COV_IRQ: cover property (@(posedge clk) disable iff (reset) $rose(device_irq));
  COV_IRQ_CLEAR: cover property (@(posedge clk) disable iff (reset) $fell(device_irq));
  COV_RC: cover property (@(posedge clk) disable iff (reset) $rose(core_clk_rc_select));
  COV_MASKED: cover property (@(posedge clk) disable iff (reset)
    |sources && !global_pending);
endmodule

// ===== host_model.sv
// Host side model: watches the interrupt pin and counts its assertions.
// Assumes the pin is an active-high level synchronous to clk.
`timescale 1ns/1ns
module host_model
(
  input  wire logic clk,
  input  wire logic irq,
  output int        seen
);
  logic last = 1'b0;
  initial seen = 0;
  always @(posedge clk)
  begin
    last <= irq;
    if (irq && !last)
      seen <= seen + 1;
  end
endmodule

// ===== device_interrupt_aggregator_tb.sv
// Testbench for the interrupt aggregator: event rows, register checks, scratch controls.
// Assumes the package offsets and the one-cycle read latency of the register port.
`timescale 1ns/1ns
module device_interrupt_aggregator_tb;
  import int_agg_pkg::*;
  typedef struct {logic [24:0] ev; logic [31:0] en; logic [31:0] sts; logic irq;} row_t;
  logic              clk   = 1'b0;
  logic              reset = 1'b1;
  logic [ADDR_W-1:0] addr  = '0;
  logic [DATA_W-1:0] wdata = '0;
  logic              wr    = 1'b0;
  logic              rd    = 1'b0;
  logic [24:0]       ev    = '0;
  logic [DATA_W-1:0] rdata, d;
  logic              irq, div_off, fb_off, div_rst, rc_sel;
  int                seen, fails = 0, tests_run = 0, cycles = 0;
  row_t              rows [11];
  logic [31:0]       scr [6];
  always #5 clk = ~clk;
  device_interrupt_aggregator i_device_interrupt_aggregator (.clk(clk), .reset(reset),
    .addr(addr), .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata), .fuse_load_fail(ev[23]),
    .rom_load_fail(ev[24]), .fuse_crc_err(ev[21]), .rom_crc_err(ev[22]),
    .fuse_manual_done(ev[20]), .los_limit_evt(ev[19:15]), .digital_loop_unlock_limit(ev[14]),
    .analog_loop_unlock_limit(ev[13]), .freq_evt(ev[12:9]), .los_evt(ev[8:4]),
    .digital_loop_state_change(ev[3]), .digital_loop_holdover(ev[2]),
    .digital_loop_unlock(ev[1]), .analog_loop_unlock(ev[0]), .device_irq(irq),
    .sysclk_div_enable_force_low(div_off), .fb_div_enable_force_low(fb_off),
    .sysclk_div_reset(div_rst), .core_clk_rc_select(rc_sel));
  host_model i_host_model (.clk(clk), .irq(irq), .seen(seen));
  task automatic check(input logic [31:0] s, input logic [31:0] e);
    tests_run++;
    if (s !== e)
    begin
      fails++;
      $display("MISMATCH t=%0t seen %h expected %h", $time, s, e);
    end
  endtask
  task automatic wr_reg(input logic [ADDR_W-1:0] a, input logic [31:0] v);
    @(posedge clk);
    addr <= a; wdata <= v; wr <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
  endtask
  task automatic rd_reg(input logic [ADDR_W-1:0] a);
    @(posedge clk);
    addr <= a; rd <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
    #1 d = rdata;
  endtask
  task automatic end_sim;
    $display("comparisons %0d mismatches %0d", tests_run, fails);
    if (fails == 0 && tests_run > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask
  // Ceiling well above the roughly 150 cycles the tests need
  always @(posedge clk)
  begin
    cycles++;
    if (cycles == 5000)
    begin
      fails++;
      end_sim();
    end
  end
  initial
  begin
    rows = '{'{25'h1, 32'h8000_0001, 32'h8000_0001, 1}, '{25'h2, 32'h8000_0001, 32'h2, 0},
      '{25'hc, 32'hc, 32'h8000_000c, 0}, '{25'h1f0, 32'h8000_0100, 32'h8000_01f0, 1},
      '{25'h1e00, 32'h8002_0000, 32'h8003_c000, 1}, '{25'h6000, 32'h8008_0000, 32'h8018_0000, 1},
      '{25'hf8000, 32'h8020_0000, 32'h83e0_0000, 1}, '{25'h30_0000, 32'h9000_0000, 32'h9800_0000, 1},
      '{25'h40_0000, 32'h9000_0000, 32'h9000_0000, 1}, '{25'h80_0000, 32'ha000_0000, 32'ha000_0000, 1},
      '{25'h100_0000, 32'h8000_0000, 32'h2000_0000, 0}};
    scr = '{32'h1, 32'h3, 32'h1, 32'hdead_bee9, 32'h1234_5674, 32'h0};
    repeat (16) @(posedge clk);
    reset <= 1'b0;
    for (int i = 0; i < 3; i++)
    begin
      rd_reg(4'(4 * i));
      check(d, RESET_WORD);
    end
    check({27'h0, div_off, fb_off, div_rst, rc_sel, irq}, 32'h0);
    $display("reset values done");
    // Rows
    foreach (rows[i])
    begin
      wr_reg(ADDR_ENABLE, rows[i].en);
      ev <= rows[i].ev;
      repeat (2) @(posedge clk);
      #1 check({31'h0, irq}, {31'h0, rows[i].irq});
      rd_reg(ADDR_STATUS);
      check(d, rows[i].sts);
    end
    $display("event rows done");
    wr_reg(ADDR_ENABLE, 32'h8000_0001);
    ev <= 25'h1;
    repeat (2) @(posedge clk);
    ev <= 25'h0;
    repeat (2) @(posedge clk);
    #1 check({31'h0, irq}, 32'h0);
    rd_reg(ADDR_STATUS);
    check(d, 32'h0);
    check({31'h0, seen != 0}, 32'h1);
    $display("event release done");
    wr_reg(ADDR_ENABLE, 32'hffff_ffff);
    rd_reg(ADDR_ENABLE);
    check(d, ENABLE_MASK);
    rd_reg(4'hc);
    check(d, 32'h0);
    $display("reserved and unmapped done");
    // Order keeps the clock switch safe: select, pulse divider reset, release
    foreach (scr[i])
    begin
      wr_reg(ADDR_SCRATCH, scr[i]);
      @(posedge clk);
      #1 check({28'h0, div_off, fb_off, div_rst, rc_sel}, {28'h0, scr[i][3:0]});
      rd_reg(ADDR_SCRATCH);
      check(d, scr[i]);
    end
    $display("scratch controls done");
    // Mid-run reset with a live event must clear registers and outputs
    wr_reg(ADDR_SCRATCH, 32'hf);
    wr_reg(ADDR_ENABLE, 32'h8000_0001);
    ev <= 25'h1;
    repeat (2) @(posedge clk);
    reset <= 1'b1;
    repeat (2) @(posedge clk);
    reset <= 1'b0;
    @(posedge clk);
    #1 check({27'h0, div_off, fb_off, div_rst, rc_sel, irq}, 32'h0);
    rd_reg(ADDR_ENABLE);
    check(d, RESET_WORD);
    rd_reg(ADDR_STATUS);
    check(d, 32'h1);
    ev <= 25'h0;
    $display("mid-run reset done");
    // Back-to-back write then read, data stands one cycle only
    @(posedge clk);
    addr <= ADDR_SCRATCH; wdata <= 32'h5a5a_0006; wr <= 1'b1;
    @(posedge clk);
    wr <= 1'b0; rd <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
    #1 check(rdata, 32'h5a5a_0006);
    @(posedge clk);
    #1 check(rdata, 32'h0);
    check({28'h0, div_off, fb_off, div_rst, rc_sel}, 32'h6);
    $display("back-to-back access done");
    end_sim();
  end
endmodule
